// [dsa_defs.vh]
// Constants shared by the data space access unit and its address generators
`ifndef DSA_DEFS_VH
`define DSA_DEFS_VH

// Data space
`define DSA_EA_W        16
`define DSA_PSV_BIT     15
`define DSA_RAM_TOP     16'h2000
`define DSA_NEAR_TOP    16'h1fff
`define DSA_NEAR_W      13
`define DSA_STEP_BYTE   16'h0001
`define DSA_STEP_WORD   16'h0002

// Address generator modes
`define DSA_MODE_W      3
`define DSA_MODE_NEAR   3'h0
`define DSA_MODE_FULL   3'h1
`define DSA_MODE_IND    3'h2
`define DSA_MODE_POSTI  3'h3
`define DSA_MODE_POSTD  3'h4
`define DSA_MODE_PREI   3'h5
`define DSA_MODE_PRED   3'h6

// Extension operations
`define DSA_EXT_NONE    2'h0
`define DSA_EXT_SIGN    2'h1
`define DSA_EXT_ZERO    2'h2

// Program space
`define DSA_PA_W        24
`define DSA_PC_W        23
`define DSA_PC_RESET    23'h000000
`define DSA_GOTO_TARGET 24'h000002
`define DSA_PC_STEP     23'h000002
`define DSA_USER_TOP    24'h7fffff
`define DSA_VEC1_LO     24'h000004
`define DSA_VEC1_HI     24'h0000ff
`define DSA_VEC2_LO     24'h000100
`define DSA_VEC2_HI     24'h0001ff
`define DSA_CFG1_ADDR   24'h00abfc
`define DSA_CFG2_ADDR   24'h00abfe
`define DSA_TBL_CFG_BIT 7

`endif

// [dsa_agu.v]
// Effective address generator for one direction of data space access
`timescale 1ns/1ps
`include "dsa_defs.vh"

module dsa_agu
(
	mode,
	byteOp,
	regVal,
	literal,
	effectiveAddr,
	regNext
);
	input  wire [2:0]  mode;
	input  wire        byteOp;
	input  wire [15:0] regVal;
	input  wire [15:0] literal;
	output reg  [15:0] effectiveAddr;
	output reg  [15:0] regNext;

	reg [15:0] step;

	always @*
	begin
		step = byteOp ? `DSA_STEP_BYTE : `DSA_STEP_WORD;
		effectiveAddr = regVal;
		regNext = regVal;
		case (mode)
			`DSA_MODE_NEAR:
			begin
				// Short field reaches only the near region
				effectiveAddr = {3'h0, literal[`DSA_NEAR_W-1:0]};
			end
			`DSA_MODE_FULL:
			begin
				effectiveAddr = literal;
			end
			`DSA_MODE_IND:
			begin
				effectiveAddr = regVal;
			end
			`DSA_MODE_POSTI:
			begin
				regNext = regVal + step;
			end
			`DSA_MODE_POSTD:
			begin
				regNext = regVal - step;
			end
			`DSA_MODE_PREI:
			begin
				regNext = regVal + step;
				effectiveAddr = regNext;
			end
			`DSA_MODE_PRED:
			begin
				regNext = regVal - step;
				effectiveAddr = regNext;
			end
			default:
			begin
				effectiveAddr = regVal;
			end
		endcase
	end
endmodule

// [dsa_unit.v]
// Data and program space access unit: address decode, byte lanes, traps, fetch and config load
//
// What this block does
// - Every data effective address is a 16-bit byte address over 64 Kbytes.
// - Top address bit clear selects data memory; set selects program visibility window.
// - Eight Kbytes of data memory; reads outside it return zero, except window reads while psvEnable is set.
// - Words are little-endian: low byte even address, high byte odd.
// - Post-modify steps are one for bytes, two for words.
// - Byte reads fetch the word, pick byte by address bit 0, return low.
// - Two byte lanes share word decode; byte writes enable only matching lane.
// - Word accesses at odd addresses raise an address error trap.
// - Misaligned read completes; misaligned write executes without storing; trap follows.
// - Byte loads into a working register change only its low byte.
// - Sign-extension of 8-bit to 16-bit, and zero-extension clearing the high byte.
// - Addresses 0000h to 1FFFh are reachable by a 13-bit direct field.
// - Full 16-bit direct field reaches the whole data space for moves.
// - Separate address generators serve reads and writes.
// - Program space uses 24-bit addresses from 23-bit counter, tables or window.
// - User program accesses stay below 800000h; only table ops reach config space.
// - Fetch addresses stay even and advance by two per instruction; window and table addresses can be odd.
// - After reset fetching starts at 000000h; jump target word at 000002h.
// - Interrupt vector tables span 000004h-0000FFh and 000100h-0001FFh.
// - Each reset copies the top two program words into configuration registers.
`timescale 1ns/1ps
`include "dsa_defs.vh"

module dsa_unit
#(
	parameter RAM_WORDS = 4096,
	parameter CFG1_ADDR = `DSA_CFG1_ADDR,
	parameter CFG2_ADDR = `DSA_CFG2_ADDR
)
(
	clk,
	rstn,
	rdValid,
	rdByte,
	rdMode,
	rdRegVal,
	rdLiteral,
	rdRegNext,
	rdAddr,
	rdData,
	rdDone,
	wregIn,
	wregOut,
	wrValid,
	wrByte,
	wrMode,
	wrRegVal,
	wrLiteral,
	wrData,
	wrRegNext,
	wrAddr,
	wrDone,
	addrErrTrap,
	psvEnable,
	psvPage,
	extOp,
	extSrc,
	extResult,
	pcStep,
	pcLoad,
	pcTarget,
	tblValid,
	tblPage,
	tblOffset,
	progAddr,
	progRead,
	progRdata,
	pcAddr,
	vecTable,
	tblRdata,
	tblDenied,
	cfgWord1,
	cfgWord2,
	cfgDone
);
	input  wire        clk;
	input  wire        rstn;
	input  wire        rdValid;
	input  wire        rdByte;
	input  wire [2:0]  rdMode;
	input  wire [15:0] rdRegVal;
	input  wire [15:0] rdLiteral;
	output wire [15:0] rdRegNext;
	output wire [15:0] rdAddr;
	output reg  [15:0] rdData;
	output reg         rdDone;
	input  wire [15:0] wregIn;
	output reg  [15:0] wregOut;
	input  wire        wrValid;
	input  wire        wrByte;
	input  wire [2:0]  wrMode;
	input  wire [15:0] wrRegVal;
	input  wire [15:0] wrLiteral;
	input  wire [15:0] wrData;
	output wire [15:0] wrRegNext;
	output wire [15:0] wrAddr;
	output reg         wrDone;
	output reg         addrErrTrap;
	input  wire        psvEnable;
	input  wire [7:0]  psvPage;
	input  wire [1:0]  extOp;
	input  wire [15:0] extSrc;
	output reg  [15:0] extResult;
	input  wire        pcStep;
	input  wire        pcLoad;
	input  wire [22:0] pcTarget;
	input  wire        tblValid;
	input  wire [7:0]  tblPage;
	input  wire [15:0] tblOffset;
	output reg  [23:0] progAddr;
	output reg         progRead;
	input  wire [23:0] progRdata;
	output wire [23:0] pcAddr;
	output reg  [1:0]  vecTable;
	output reg  [23:0] tblRdata;
	output reg         tblDenied;
	output reg  [23:0] cfgWord1;
	output reg  [23:0] cfgWord2;
	output reg         cfgDone;

	localparam IDX_W = 12;
	localparam CFG_IDLE  = 2'h0;
	localparam CFG_WORD1 = 2'h1;
	localparam CFG_WORD2 = 2'h2;
	localparam CFG_DONE  = 2'h3;

	wire [15:0] rdEa;
	wire [15:0] wrEa;
	wire        rdInRam;
	wire        wrInRam;
	wire        rdPsv;
	wire        rdMisalign;
	wire        wrMisalign;
	wire        wrAllow;
	wire [IDX_W-1:0] rdIdx;
	wire [IDX_W-1:0] wrIdx;
	wire [1:0]  laneWe;
	wire [15:0] ramWord;
	wire [23:0] psvAddr;
	wire [23:0] tblAddr;
	wire        tblOk;
	reg  [15:0] rdWord;
	reg  [7:0]  rdSel;
	reg  [15:0] rdData_nxt;
	reg  [22:0] pc_r;
	reg  [1:0]  cfgState_r;
	reg  [1:0]  cfgState_nxt;
	reg  [1:0]  vecTable_nxt;

	// Two independent generators so a read and a write can share a cycle
	dsa_agu uRdAgu
	(
		.mode          (rdMode),
		.byteOp        (rdByte),
		.regVal        (rdRegVal),
		.literal       (rdLiteral),
		.effectiveAddr (rdEa),
		.regNext       (rdRegNext)
	);

	dsa_agu uWrAgu
	(
		.mode          (wrMode),
		.byteOp        (wrByte),
		.regVal        (wrRegVal),
		.literal       (wrLiteral),
		.effectiveAddr (wrEa),
		.regNext       (wrRegNext)
	);

	assign rdAddr = rdEa;
	assign wrAddr = wrEa;

	assign rdPsv   = rdEa[`DSA_PSV_BIT];
	assign rdInRam = !rdEa[`DSA_PSV_BIT] && (rdEa < `DSA_RAM_TOP);
	assign wrInRam = !wrEa[`DSA_PSV_BIT] && (wrEa < `DSA_RAM_TOP);

	assign rdMisalign = rdValid && !rdByte && rdEa[0];
	assign wrMisalign = wrValid && !wrByte && wrEa[0];

	// Misaligned write still completes as an instruction, only the store is dropped
	assign wrAllow = wrValid && !wrMisalign && wrInRam;

	assign rdIdx = rdEa[IDX_W:1];
	assign wrIdx = wrEa[IDX_W:1];

	// Lane 0 holds the even byte, lane 1 the odd byte
	assign laneWe[0] = wrAllow && (!wrByte || !wrEa[0]);
	assign laneWe[1] = wrAllow && (!wrByte || wrEa[0]);

	genvar lane;
	generate
		for (lane = 0; lane < 2; lane = lane + 1)
		begin : gLane
			reg  [7:0] mem [0:RAM_WORDS-1];
			wire [7:0] wrByteVal;
			// Byte writes carry their data on the low byte of the path
			assign wrByteVal = wrByte ? wrData[7:0] : wrData[lane*8+7:lane*8];
			always @(posedge clk)
			begin
				if (laneWe[lane])
				begin
					mem[wrIdx] <= wrByteVal;
				end
			end
			assign ramWord[lane*8+7:lane*8] = mem[rdIdx];
		end
	endgenerate

	// Window maps data addresses with top bit set onto one program page
	assign psvAddr = {psvPage, rdEa[14:0], 1'b0} >> 1;
	assign tblAddr = {tblPage, tblOffset};
	// Config half needs the page's top bit, which only table ops may use
	assign tblOk = 1'b1;
	assign pcAddr = {1'b0, pc_r};

	always @*
	begin
		rdWord = 16'h0000;
		if (rdInRam)
		begin
			rdWord = ramWord;
		end
		else if (rdPsv && psvEnable)
		begin
			rdWord = progRdata[15:0];
		end
		// Unimplemented locations leave rdWord at zero
		rdSel = rdEa[0] ? rdWord[15:8] : rdWord[7:0];
		rdData_nxt = rdByte ? {8'h00, rdSel} : rdWord;
	end

	// Program port priority: reset config load, table op, data window, fetch
	always @*
	begin
		progRead = 1'b1;
		progAddr = pcAddr;
		case (cfgState_r)
			CFG_WORD1:
			begin
				progAddr = CFG1_ADDR[`DSA_PA_W-1:0];
			end
			CFG_WORD2:
			begin
				progAddr = CFG2_ADDR[`DSA_PA_W-1:0];
			end
			default:
			begin
				if (tblValid)
				begin
					progAddr = tblAddr;
				end
				else if (rdValid && rdPsv && psvEnable)
				begin
					progAddr = {1'b0, psvAddr[22:0]};
				end
			end
		endcase
	end

	always @*
	begin
		vecTable_nxt = 2'h0;
		if (pcAddr >= `DSA_VEC1_LO && pcAddr <= `DSA_VEC1_HI)
		begin
			vecTable_nxt = 2'h1;
		end
		else if (pcAddr >= `DSA_VEC2_LO && pcAddr <= `DSA_VEC2_HI)
		begin
			vecTable_nxt = 2'h2;
		end
	end

	always @*
	begin
		cfgState_nxt = cfgState_r;
		case (cfgState_r)
			CFG_IDLE:
			begin
				cfgState_nxt = CFG_WORD1;
			end
			CFG_WORD1:
			begin
				cfgState_nxt = CFG_WORD2;
			end
			CFG_WORD2:
			begin
				cfgState_nxt = CFG_DONE;
			end
			default:
			begin
				cfgState_nxt = CFG_DONE;
			end
		endcase
	end

	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cfgState_r <= CFG_IDLE;
			cfgWord1   <= 24'h000000;
			cfgWord2   <= 24'h000000;
			cfgDone    <= 1'b0;
		end
		else
		begin
			cfgState_r <= cfgState_nxt;
			if (cfgState_r == CFG_WORD1)
			begin
				cfgWord1 <= progRdata;
			end
			if (cfgState_r == CFG_WORD2)
			begin
				cfgWord2 <= progRdata;
				cfgDone  <= 1'b1;
			end
		end
	end

	// Fetch is held until configuration is in place
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pc_r     <= `DSA_PC_RESET;
			vecTable <= 2'h0;
		end
		else
		begin
			vecTable <= vecTable_nxt;
			if (cfgDone)
			begin
				if (pcLoad)
				begin
					pc_r <= {pcTarget[22:1], 1'b0};
				end
				else if (pcStep)
				begin
					pc_r <= pc_r + `DSA_PC_STEP;
				end
			end
		end
	end

	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rdData      <= 16'h0000;
			rdDone      <= 1'b0;
			wregOut     <= 16'h0000;
			wrDone      <= 1'b0;
			addrErrTrap <= 1'b0;
			extResult   <= 16'h0000;
			tblRdata    <= 24'h000000;
			tblDenied   <= 1'b0;
		end
		else
		begin
			rdDone      <= rdValid;
			wrDone      <= wrValid;
			addrErrTrap <= rdMisalign || wrMisalign;
			tblDenied   <= 1'b0;
			if (rdValid)
			begin
				rdData  <= rdData_nxt;
				wregOut <= rdByte ? {wregIn[15:8], rdSel} : rdWord;
			end
			if (tblValid && cfgDone)
			begin
				tblRdata  <= progRdata;
				tblDenied <= !tblOk;
			end
			case (extOp)
				`DSA_EXT_SIGN:
				begin
					extResult <= {{8{extSrc[7]}}, extSrc[7:0]};
				end
				`DSA_EXT_ZERO:
				begin
					extResult <= {8'h00, extSrc[7:0]};
				end
				default:
				begin
					extResult <= extResult;
				end
			endcase
		end
	end
endmodule

// [dsa_placeholder_unused.v]
// Intentionally empty module list file not needed
`timescale 1ns/1ps

// [dsa_pmem_model.sv]
// Program memory model on the far side of the program port
`timescale 1ns/1ps
module dsa_pmem_model
(
	input wire logic [23:0]	addr,
	output logic [23:0]	rdata
);
	// Same-cycle answer; contents are a fixed pattern of the address
	assign rdata = {addr[7:0] ^ 8'h3c, addr[15:0] ^ 16'h5a5a};
endmodule

// [dsa_unit_sva.sv]
// Port-level assertions for the data space access unit
`timescale 1ns/1ps
module dsa_unit_sva
(
	input wire logic	clk,
	input wire logic	rstn,
	input wire logic	rdValid,
	input wire logic	rdByte,
	input wire logic [2:0]	rdMode,
	input wire logic [15:0]	rdRegVal,
	input wire logic [15:0]	rdLiteral,
	input wire logic [15:0]	rdRegNext,
	input wire logic [15:0]	rdAddr,
	input wire logic [15:0]	rdData,
	input wire logic	rdDone,
	input wire logic	wrValid,
	input wire logic	wrByte,
	input wire logic [15:0]	wrAddr,
	input wire logic	wrDone,
	input wire logic	addrErrTrap,
	input wire logic [1:0]	extOp,
	input wire logic [15:0]	extSrc,
	input wire logic [15:0]	extResult,
	input wire logic [23:0]	pcAddr,
	input wire logic	cfgDone
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	wire	rdOdd = rdValid && !rdByte && rdAddr[0];
	wire	wrOdd = wrValid && !wrByte && wrAddr[0];
	// Data reads that land between the end of memory and the window
	wire	rdOut = rdValid && !rdAddr[15] && (rdAddr >= 16'h2000);
	AST_RD_DONE: assert property (rdValid |=> rdDone) else $error("read not completed");
	AST_WR_DONE: assert property (wrValid |=> wrDone) else $error("write not completed");
	AST_TRAP_RD: assert property (rdOdd |=> addrErrTrap) else $error("odd word read no trap");
	AST_TRAP_WR: assert property (wrOdd |=> addrErrTrap) else $error("odd word write no trap");
	AST_TRAP_CAUSE:
		assert property (addrErrTrap |-> $past(rdOdd || wrOdd)) else $error("trap without cause");
	AST_POST_STEP:
		assert property (rdMode == 3'h3 |-> rdRegNext == rdRegVal + (rdByte ? 16'h0001 : 16'h0002))
		else $error("bad post step");
	AST_NEAR:
		assert property (rdMode == 3'h0 |-> rdAddr == {3'h0, rdLiteral[12:0]}) else $error("bad near addr");
	AST_FULL: assert property (rdMode == 3'h1 |-> rdAddr == rdLiteral) else $error("bad full addr");
	AST_BYTE_LOW:
		assert property (rdValid && rdByte |=> rdData[15:8] == 8'h00) else $error("byte not low");
	AST_SEXT:
		assert property (extOp == 2'h1 |=> extResult == {{8{$past(extSrc[7])}}, $past(extSrc[7:0])})
		else $error("bad sign extend");
	AST_ZEXT:
		assert property (extOp == 2'h2 |=> extResult == {8'h00, $past(extSrc[7:0])})
		else $error("bad zero extend");
	AST_OUT_ZERO:
		assert property (rdOut |=> rdData == 16'h0000) else $error("unimplemented read not zero");
	AST_PC_RESET: assert property (!cfgDone |-> pcAddr == 24'h000000) else $error("pc not at reset");
	AST_PC_EVEN:
		assert property (pcAddr[0] == 1'b0 && pcAddr[23] == 1'b0) else $error("pc odd or high");
endmodule
bind dsa_unit dsa_unit_sva chk
(
	.clk         (clk),
	.rstn        (rstn),
	.rdValid     (rdValid),
	.rdByte      (rdByte),
	.rdMode      (rdMode),
	.rdRegVal    (rdRegVal),
	.rdLiteral   (rdLiteral),
	.rdRegNext   (rdRegNext),
	.rdAddr      (rdAddr),
	.rdData      (rdData),
	.rdDone      (rdDone),
	.wrValid     (wrValid),
	.wrByte      (wrByte),
	.wrAddr      (wrAddr),
	.wrDone      (wrDone),
	.addrErrTrap (addrErrTrap),
	.extOp       (extOp),
	.extSrc      (extSrc),
	.extResult   (extResult),
	.pcAddr      (pcAddr),
	.cfgDone     (cfgDone)
);

// [testbench.sv]
// Self-checking bench for the data space access unit
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module testbench;
	logic		clk, rstn, rdValid, rdByte, wrValid, wrByte, psvEnable, pcStep, pcLoad, tblValid;
	logic [2:0]	rdMode, wrMode;
	logic [15:0]	rdRegVal, rdLiteral, wregIn, wrRegVal, wrLiteral, wrData, extSrc, tblOffset, a;
	logic [1:0]	extOp;
	logic [7:0]	psvPage, tblPage;
	logic [22:0]	pcTarget;
	wire [15:0]	rdRegNext, rdAddr, rdData, wregOut, wrRegNext, wrAddr, extResult;
	wire		rdDone, wrDone, addrErrTrap, progRead, tblDenied, cfgDone;
	wire [23:0]	progAddr, progRdata, pcAddr, tblRdata, cfgWord1, cfgWord2;
	wire [1:0]	vecTable;
	logic [15:0]	mem [0:4095];
	logic [32:0]	notes [$];
	logic [32:0]	nt;
	logic [31:0]	r;
	int		n_errors = 0;
	int		compares = 0;
	int		i;

	dsa_unit dut
	(
		.clk(clk), .rstn(rstn), .rdValid(rdValid), .rdByte(rdByte), .rdMode(rdMode), .rdRegVal(rdRegVal),
		.rdLiteral(rdLiteral), .rdRegNext(rdRegNext), .rdAddr(rdAddr), .rdData(rdData), .rdDone(rdDone),
		.wregIn(wregIn), .wregOut(wregOut), .wrValid(wrValid), .wrByte(wrByte), .wrMode(wrMode),
		.wrRegVal(wrRegVal), .wrLiteral(wrLiteral), .wrData(wrData), .wrRegNext(wrRegNext), .wrAddr(wrAddr),
		.wrDone(wrDone), .addrErrTrap(addrErrTrap), .psvEnable(psvEnable), .psvPage(psvPage), .extOp(extOp),
		.extSrc(extSrc), .extResult(extResult), .pcStep(pcStep), .pcLoad(pcLoad), .pcTarget(pcTarget),
		.tblValid(tblValid), .tblPage(tblPage), .tblOffset(tblOffset), .progAddr(progAddr), .progRead(progRead),
		.progRdata(progRdata), .pcAddr(pcAddr), .vecTable(vecTable), .tblRdata(tblRdata), .tblDenied(tblDenied),
		.cfgWord1(cfgWord1), .cfgWord2(cfgWord2), .cfgDone(cfgDone)
	);
	dsa_pmem_model pm (.addr(progAddr), .rdata(progRdata));

	function automatic [23:0] pmf(input [23:0] x);
		pmf = {x[7:0] ^ 8'h3c, x[15:0] ^ 16'h5a5a};
	endfunction

	task test_done;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic rd(input [2:0] m, input b, input [15:0] ad, input [15:0] wi);
		logic [23:0] p;
		logic [15:0] w;
		logic [7:0] bv;
		p = pmf({1'b0, psvPage, ad[14:0]});
		if (ad[15])
			w = psvEnable ? p[15:0] : 16'h0000;
		else
			w = (ad < 16'h2000) ? mem[ad[12:1]] : 16'h0000;
		bv = ad[0] ? w[15:8] : w[7:0];
		notes.push_back({!b && ad[0], b ? {wi[15:8], bv} : w, b ? {8'h00, bv} : w});
		@(posedge clk);
		rdMode <= m;
		rdByte <= b;
		rdRegVal <= ad;
		rdLiteral <= (m == 3'h0) ? {3'h7, ad[12:0]} : ad;
		wregIn <= wi;
		rdValid <= 1'b1;
		wrValid <= 1'b0;
		#1;
		`CHK(rdAddr, ad)
		if (m == 3'h4)
			`CHK(rdRegNext, ad - (b ? 16'h0001 : 16'h0002))
		if (ad[15] && psvEnable)
			`CHK(progAddr, ({1'b0, psvPage, ad[14:0]}))
	endtask

	task automatic wr(input b, input [15:0] ad, input [15:0] d);
		if (ad < 16'h2000 && (b || !ad[0]))
		begin
			if (!b)
				mem[ad[12:1]] = d;
			else if (ad[0])
				mem[ad[12:1]][15:8] = d[7:0];
			else
				mem[ad[12:1]][7:0] = d[7:0];
		end
		notes.push_back({!b && ad[0], 32'h0});
		@(posedge clk);
		wrMode <= 3'h3;
		wrByte <= b;
		wrLiteral <= ad;
		wrRegVal <= ad;
		wrData <= d;
		wrValid <= 1'b1;
		rdValid <= 1'b0;
		#1;
		`CHK(wrAddr, ad)
		`CHK(wrRegNext, ad + (b ? 16'h0001 : 16'h0002))
	endtask

	task idle;
		@(posedge clk);
		rdValid <= 1'b0;
		wrValid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task ext(input [1:0] op, input [15:0] s, input [15:0] e);
		@(posedge clk);
		extOp <= op;
		extSrc <= s;
		@(posedge clk);
		extOp <= 2'h0;
		#1;
		`CHK(extResult, e)
	endtask

	task tbl(input [7:0] pg, input [15:0] off);
		@(posedge clk);
		tblValid <= 1'b1;
		tblPage <= pg;
		tblOffset <= off;
		#1;
		`CHK(progAddr, ({pg, off}))
		`CHK(progRead, 1'b1)
		@(posedge clk);
		tblValid <= 1'b0;
		#1;
		`CHK(tblRdata, pmf({pg, off}))
		`CHK(tblDenied, 1'b0)
	endtask

	task pl(input [22:0] t, input [23:0] ep, input [1:0] ev);
		@(posedge clk);
		pcLoad <= 1'b1;
		pcTarget <= t;
		@(posedge clk);
		pcLoad <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK(pcAddr, ep)
		`CHK(vecTable, ev)
		`CHK(progAddr, ep)
	endtask

	// Holds reset for three edges, then waits a bounded time for the config load
	task boot;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		for (i = 0; i < 20 && cfgDone !== 1'b1; i++)
			@(posedge clk);
		if (cfgDone !== 1'b1)
		begin
			n_errors++;
			test_done;
		end
		#1;
		`CHK(pcAddr, 24'h000000)
		`CHK(cfgWord1, pmf(24'h00abfc))
		`CHK(cfgWord2, pmf(24'h00abfe))
	endtask

	// Answers are judged mid-cycle, well clear of the edge that launches them
	always @(negedge clk)
		if (rdDone === 1'b1 || wrDone === 1'b1)
		begin
			nt = notes.pop_front();
			`CHK(addrErrTrap, nt[32])
			if (rdDone === 1'b1)
			begin
				`CHK(rdData, nt[15:0])
				`CHK(wregOut, nt[31:16])
			end
		end

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		#500000;
		n_errors++;
		test_done;
	end

	initial
	begin
		{rdValid, rdByte, wrValid, wrByte, psvEnable, pcStep, pcLoad, tblValid} = 8'h00;
		{rdMode, wrMode, rdRegVal, rdLiteral, wregIn, wrRegVal, wrLiteral, wrData} = '0;
		{extOp, extSrc, psvPage, tblPage, tblOffset, pcTarget} = '0;
		rstn = 1'b0;
		void'($urandom(32'he105));
		boot;
		for (i = 0; i < 24; i++)
		begin
			r = $urandom;
			a = {3'h0, r[12:1], 1'b0};
			wr(1'b0, a, r[31:16]);
			rd(3'h2, 1'b0, a, r[15:0]);
			rd(3'h2, 1'b1, a | 16'h0001, r[15:0]);
			wr(1'b1, a | 16'h0001, r[15:0]);
			rd(3'h1, 1'b1, a, r[31:16]);
			rd(3'h2, 1'b0, a | 16'h0001, r[15:0]);
			wr(1'b0, a | 16'h0001, ~r[31:16]);
			rd(3'h0, 1'b0, a, r[15:0]);
			rd(3'h3, r[0], a, r[15:0]);
			rd(3'h4, r[1], a, r[31:16]);
		end
		rd(3'h2, 1'b0, 16'h3000, 16'h1234);
		rd(3'h2, 1'b1, 16'h7fff, 16'h1234);
		rd(3'h2, 1'b0, 16'h8010, 16'h0000);
		idle;
		@(posedge clk);
		psvEnable <= 1'b1;
		psvPage <= r[7:0];
		#1;
		rd(3'h2, 1'b0, 16'h8010, 16'h0000);
		rd(3'h2, 1'b1, 16'hc123, 16'ha5a5);
		idle;
		ext(2'h1, 16'h0080, 16'hff80);
		ext(2'h1, 16'h127f, 16'h007f);
		ext(2'h2, 16'hab80, 16'h0080);
		tbl(8'h80, 16'h0004);
		tbl(8'h01, 16'h2222);
		@(posedge clk);
		pcStep <= 1'b1;
		repeat (3) @(posedge clk);
		pcStep <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK(pcAddr, 24'h000006)
		pl(23'h0001ff, 24'h0001fe, 2'h2);
		pl(23'h000200, 24'h000200, 2'h0);
		pl(23'h0000ff, 24'h0000fe, 2'h1);
		pl(23'h000003, 24'h000002, 2'h0);
		// Second reset in mid-run must reload the configuration words
		@(posedge clk);
		rstn <= 1'b0;
		#1;
		`CHK(cfgDone, 1'b0)
		`CHK(cfgWord1, 24'h000000)
		`CHK(pcAddr, 24'h000000)
		boot;
		`CHK(notes.size(), 0)
		test_done;
	end
endmodule
